// File: dirlc_top.v
// ISA adapter glue: DMA request routing, interrupt select and line test control
// Overview of operation
// - Tx request from terminal or wait pin
// - Rx request from channel B or A wait
// - Tx gate bit passes or blocks request
// - Rx gate bit passes or blocks request
// - Two-bit field selects interrupt source
// - Reserved bits always read zero
// - Tx request raised when buffer empties
// - Rx request raised when character arrives
// - Bit seven shows test level, also interrupt source code three
// - Local loop bit drives local loop output
// - Remote loop bit drives remote output, sync output only with jumper
// - Rx clock drive only in DCE
// - Tx clock drive bit in DTE, forced on in DCE
// - Decode routing at five, line at four
`timescale 1ns/100ps
`include "dirlc_defines.vh"
module dirlc_top (
   // Clock and reset
   input  wire       mclk,
   input  wire       sys_rst,
   // ISA I/O access (card-local offset)
   input  wire       io_sel,
   input  wire [2:0] io_addr,
   input  wire       io_wr,
   input  wire       io_rd,
   input  wire [7:0] io_wdata,
   output reg  [7:0] io_rdata,
   output reg        io_rvalid,
   // Serial controller request and interrupt pins
   input  wire       chan_a_wait_request,
   input  wire       chan_b_wait_request,
   input  wire       chan_a_terminal_request,
   input  wire       controller_interrupt,
   // System DMA terminal count and line test input
   input  wire       terminal_count_interrupt,
   input  wire       test_mode_level,
   // Jumper straps
   input  wire       dce_config,
   input  wire       sync_jumper,
   // ISA requests and interrupt
   output reg        tx_drq,
   output reg        rx_drq,
   output reg        irq_out,
   // Line test and clock direction
   output reg        local_loop_out,
   output reg        remote_loop_out,
   output reg        chan_a_sync_out,
   output reg        rx_clock_out_en,
   output reg        tx_clock_out_en
);

   //---------------------------------------------------------------
   // Input synchronisers
   //---------------------------------------------------------------
   wire [7:0] pins_sync;
   wire       wreq_a_s;
   wire       wreq_b_s;
   wire       treq_a_s;
   wire       cirq_s;
   wire       tc_s;
   wire       tm_s;
   wire       dce_s;
   wire       jmp_s;

   dirlc_sync2 #(
      .W (8)
   ) u_sync (
      .mclk     (mclk),
      .sys_rst  (sys_rst),
      .async_in ({sync_jumper, dce_config, test_mode_level, terminal_count_interrupt,
                  controller_interrupt, chan_a_terminal_request, chan_b_wait_request,
                  chan_a_wait_request}),
      .sync_out (pins_sync)
   );

   // Unpack synchronised pins
   assign wreq_a_s = pins_sync[0];
   assign wreq_b_s = pins_sync[1];
   assign treq_a_s = pins_sync[2];
   assign cirq_s   = pins_sync[3];
   assign tc_s     = pins_sync[4];
   assign tm_s     = pins_sync[5];
   assign dce_s    = pins_sync[6];
   assign jmp_s    = pins_sync[7];

   //---------------------------------------------------------------
   // Registers
   //---------------------------------------------------------------
   reg  [5:0] route_reg;
   reg  [5:0] route_next;
   reg        lloop_reg;
   reg        rloop_reg;
   reg        rxclk_reg;
   reg        txclk_reg;
   reg        lloop_next;
   reg        rloop_next;
   reg        rxclk_next;
   reg        txclk_next;
   wire       wr_route;
   wire       wr_line;

   // Address decode
   assign wr_route = io_sel & io_wr & (io_addr == `DIRLC_OFS_ROUTE);
   assign wr_line  = io_sel & io_wr & (io_addr == `DIRLC_OFS_LINE);

   // Next-state for writable fields
   always @* begin
      route_next = route_reg;
      lloop_next = lloop_reg;
      rloop_next = rloop_reg;
      rxclk_next = rxclk_reg;
      txclk_next = txclk_reg;
      if (wr_route) begin
         route_next = io_wdata[5:0]; // Top two bits dropped
      end
      if (wr_line) begin
         lloop_next = io_wdata[`DIRLC_LLOOP];
         rloop_next = io_wdata[`DIRLC_RLOOP];
         // Rx clock drive only takes writes in DCE
         if (dce_s) begin
            rxclk_next = io_wdata[`DIRLC_RX_CLK];
         end
         // Tx clock drive only takes writes in DTE
         if (!dce_s) begin
            txclk_next = io_wdata[`DIRLC_TX_CLK];
         end
      end
   end

   // Register storage, cleared on reset
   always @(posedge mclk) begin
      if (sys_rst) begin
         route_reg <= 6'h00;
         lloop_reg <= `DIRLC_RST_BIT;
         rloop_reg <= `DIRLC_RST_BIT;
         rxclk_reg <= `DIRLC_RST_BIT;
         txclk_reg <= `DIRLC_RST_BIT;
      end else begin
         route_reg <= route_next;
         lloop_reg <= lloop_next;
         rloop_reg <= rloop_next;
         rxclk_reg <= rxclk_next;
         txclk_reg <= txclk_next;
      end
   end

   //---------------------------------------------------------------
   // Read path
   //---------------------------------------------------------------
   reg [7:0] rd_mux;

   // Read data select; reserved and low bits read zero
   always @* begin
      rd_mux = `DIRLC_RST_BYTE;
      if (io_addr == `DIRLC_OFS_ROUTE) begin
         rd_mux = {2'h0, route_reg};
      end else if (io_addr == `DIRLC_OFS_LINE) begin
         rd_mux = {tm_s, 1'h0, lloop_reg, rloop_reg, rxclk_reg, txclk_reg, 2'h0};
      end
   end

   // Registered read answer, one cycle after strobe
   always @(posedge mclk) begin
      if (sys_rst) begin
         io_rdata  <= `DIRLC_RST_BYTE;
         io_rvalid <= 1'b0;
      end else begin
         io_rvalid <= io_sel & io_rd;
         io_rdata  <= (io_sel & io_rd) ? rd_mux : `DIRLC_RST_BYTE;
      end
   end

   //---------------------------------------------------------------
   // DMA request routing
   //---------------------------------------------------------------
   wire tx_src;
   wire rx_src;
   wire [1:0] int_sel;
   reg  irq_mux;

   // Controller raises its pin on empty buffer / arrived char
   assign tx_src = route_reg[`DIRLC_TX_SEL] ? treq_a_s : wreq_a_s;
   assign rx_src = route_reg[`DIRLC_RX_SEL] ? wreq_b_s : wreq_a_s;
   assign int_sel = route_reg[`DIRLC_INT_HI:`DIRLC_INT_LO];

   // Interrupt source select
   always @* begin
      case (int_sel)
         `DIRLC_INT_TC:   irq_mux = tc_s;
         `DIRLC_INT_CTRL: irq_mux = cirq_s;
         `DIRLC_INT_TEST: irq_mux = tm_s;
         default:         irq_mux = 1'b0;   // Disabled
      endcase
   end

   // Output flops
   always @(posedge mclk) begin
      if (sys_rst) begin
         tx_drq          <= 1'b0;
         rx_drq          <= 1'b0;
         irq_out         <= 1'b0;
         local_loop_out  <= 1'b0;
         remote_loop_out <= 1'b0;
         chan_a_sync_out <= 1'b0;
         rx_clock_out_en <= 1'b0;
         tx_clock_out_en <= 1'b0;
      end else begin
         tx_drq          <= tx_src & route_reg[`DIRLC_TX_GATE];
         rx_drq          <= rx_src & route_reg[`DIRLC_RX_GATE];
         irq_out         <= irq_mux;
         local_loop_out  <= lloop_reg;
         remote_loop_out <= rloop_reg;
         chan_a_sync_out <= rloop_reg & jmp_s;
         rx_clock_out_en <= rxclk_reg & dce_s;
         tx_clock_out_en <= txclk_reg | dce_s;
      end
   end

endmodule // dirlc_top

// File: dirlc_defines.vh
// Register offsets, field positions and reset values for the DMA/IRQ routing block
`ifndef DIRLC_DEFINES_VH
`define DIRLC_DEFINES_VH
// Register offsets from the card base
`define DIRLC_OFS_LINE     3'h4
`define DIRLC_OFS_ROUTE    3'h5
// Routing register fields
`define DIRLC_TX_SEL       0
`define DIRLC_RX_SEL       1
`define DIRLC_TX_GATE      2
`define DIRLC_RX_GATE      3
`define DIRLC_INT_LO       4
`define DIRLC_INT_HI       5
// Interrupt source codes
`define DIRLC_INT_OFF      2'h0
`define DIRLC_INT_TC       2'h1
`define DIRLC_INT_CTRL     2'h2
`define DIRLC_INT_TEST     2'h3
// Line register fields
`define DIRLC_TX_CLK       2
`define DIRLC_RX_CLK       3
`define DIRLC_RLOOP        4
`define DIRLC_LLOOP        5
`define DIRLC_TEST_LVL     7
// Reset values
`define DIRLC_RST_BYTE     8'h00
`define DIRLC_RST_BIT      1'h0
`endif

// File: dirlc_sync2.v
// Two-flop synchroniser for a bank of asynchronous inputs
`timescale 1ns/100ps
module dirlc_sync2 #(
   parameter W = 8
) (
   // Clock and reset
   input  wire         mclk,
   input  wire         sys_rst,
   // Data
   input  wire [W-1:0] async_in,
   output reg  [W-1:0] sync_out
);
   reg [W-1:0] meta_reg;

   // First stage read only by the second stage
   always @(posedge mclk) begin
      if (sys_rst) begin
         meta_reg <= {W{1'b0}};
         sync_out <= {W{1'b0}};
      end else begin
         meta_reg <= async_in;
         sync_out <= meta_reg;
      end
   end
endmodule // dirlc_sync2

// File: dirlc_checker.sv
// Port assertions for the routing and line control block
`timescale 1ns/100ps
module dirlc_checker (
   // Bus side
   input logic       mclk,
   input logic       sys_rst,
   input logic       io_sel,
   input logic [2:0] io_addr,
   input logic       io_wr,
   input logic       io_rd,
   input logic [7:0] io_wdata,
   input logic [7:0] io_rdata,
   input logic       io_rvalid,
   // Pins
   input logic       chan_a_wait_request,
   input logic       chan_b_wait_request,
   input logic       chan_a_terminal_request,
   input logic       controller_interrupt,
   input logic       terminal_count_interrupt,
   input logic       test_mode_level,
   input logic       dce_config,
   input logic       tx_drq,
   input logic       rx_drq,
   input logic       irq_out,
   input logic       local_loop_out,
   input logic       remote_loop_out,
   input logic       rx_clock_out_en,
   input logic       tx_clock_out_en
);
   reg [5:0] cfg_reg;
   reg [5:2] line_reg;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   // Shadow copies of both registers, loaded by bus writes
   always @(posedge mclk) begin
      if (sys_rst) begin
         cfg_reg  <= 6'h00;
         line_reg <= 4'h0;
      end else if (io_sel && io_wr && io_addr == 3'h5) begin
         cfg_reg <= io_wdata[5:0];
      end else if (io_sel && io_wr && io_addr == 3'h4) begin
         line_reg <= {io_wdata[5:4], dce_config ? io_wdata[3] : line_reg[3],
                      dce_config ? line_reg[2] : io_wdata[2]};
      end
   end
   // Everything unchanged long enough for the synchronisers to settle
   sequence s_calm;
      $stable({cfg_reg, line_reg, sys_rst, dce_config, chan_a_wait_request, chan_b_wait_request,
               chan_a_terminal_request, controller_interrupt, terminal_count_interrupt,
               test_mode_level}) [*4];
   endsequence
   a_tx_route: assert property (s_calm |->
      tx_drq == (cfg_reg[2] && (cfg_reg[0] ? chan_a_terminal_request : chan_a_wait_request)))
      else $error("tx request wrong");
   a_rx_route: assert property (s_calm |->
      rx_drq == (cfg_reg[3] && (cfg_reg[1] ? chan_b_wait_request : chan_a_wait_request)))
      else $error("rx request wrong");
   a_irq_select: assert property (s_calm |-> irq_out == (cfg_reg[5:4] == 2'h1 ?
      terminal_count_interrupt : cfg_reg[5:4] == 2'h2 ? controller_interrupt :
      cfg_reg[5:4] == 2'h3 && test_mode_level)) else $error("interrupt select wrong");
   a_loop_out: assert property (s_calm |->
      local_loop_out == line_reg[5] && remote_loop_out == line_reg[4])
      else $error("loop output wrong");
   a_clock_drive: assert property (s_calm |->
      rx_clock_out_en == (line_reg[3] && dce_config) &&
      tx_clock_out_en == (line_reg[2] || dce_config)) else $error("clock drive wrong");
   a_read_pulse: assert property (io_sel && io_rd |=> io_rvalid)
      else $error("read answer missing");
   a_route_read: assert property (io_rvalid && $past(io_addr) == 3'h5 |->
      io_rdata == {2'h0, $past(cfg_reg)}) else $error("routing read wrong");
   a_line_read: assert property (io_rvalid && $past(io_addr) == 3'h4 |->
      io_rdata[6:0] == {1'b0, $past(line_reg), 2'h0}) else $error("line read wrong");
endmodule // dirlc_checker
bind dirlc_top dirlc_checker dirlc_checker_i (.mclk, .sys_rst, .io_sel, .io_addr, .io_wr,
   .io_rd, .io_wdata, .io_rdata, .io_rvalid, .chan_a_wait_request, .chan_b_wait_request,
   .chan_a_terminal_request, .controller_interrupt, .terminal_count_interrupt,
   .test_mode_level, .dce_config, .tx_drq, .rx_drq, .irq_out, .local_loop_out,
   .remote_loop_out, .rx_clock_out_en, .tx_clock_out_en);

// File: dirlc_scc_model.sv
// Serial controller pin model for the routing bench
`timescale 1ns/100ps
module dirlc_scc_model (
   input  wire       mclk,
   input  wire [5:0] lv,
   output reg  [5:0] pins = 6'h00
);
   // Requests, interrupts and test level move just after the falling edge
   always @(negedge mclk) pins <= lv;
endmodule // dirlc_scc_model

// File: tb_dirlc_top.sv
// Self-checking bench for the DMA routing and line control block
`timescale 1ns/100ps
module tb_dirlc_top;
   reg        mclk = 1'b0, sys_rst = 1'b1, io_sel = 1'b0, io_wr = 1'b0, io_rd = 1'b0;
   reg        dce = 1'b0, jmp = 1'b0;
   reg  [2:0] io_addr = 3'h0;
   reg  [7:0] io_wdata = 8'h00, v;
   reg  [5:0] lv = 6'h00;
   reg  [5:2] lx;
   reg [31:0] rnd = 32'he7728e58;
   wire [5:0] pins;
   wire [7:0] io_rdata, outs;
   wire       io_rvalid;
   integer    err_count = 0, checked = 0, i;
   // Bus clock
   always #50 mclk = ~mclk;
   dirlc_scc_model dirlc_scc_model_i (.mclk(mclk), .lv(lv), .pins(pins));
   dirlc_top dirlc_top_i (.mclk(mclk), .sys_rst(sys_rst), .io_sel(io_sel), .io_addr(io_addr),
      .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(io_rdata),
      .io_rvalid(io_rvalid), .chan_a_wait_request(pins[0]), .chan_b_wait_request(pins[1]),
      .chan_a_terminal_request(pins[2]), .controller_interrupt(pins[3]),
      .terminal_count_interrupt(pins[4]), .test_mode_level(pins[5]), .dce_config(dce),
      .sync_jumper(jmp), .tx_drq(outs[0]), .rx_drq(outs[1]), .irq_out(outs[2]),
      .local_loop_out(outs[7]), .remote_loop_out(outs[6]), .chan_a_sync_out(outs[5]),
      .rx_clock_out_en(outs[4]), .tx_clock_out_en(outs[3]));
   function [31:0] xs(input [31:0] x);
      reg [31:0] y;
      begin
         y = x ^ (x << 13);
         y = y ^ (y >> 17);
         xs = y ^ (y << 5);
      end
   endfunction
   // Expected interrupt, rx and tx requests from routing bits and pin levels
   function [2:0] route(input [5:0] c, input [5:0] p);
      route = {c[5:4] == 2'h1 ? p[4] : c[5:4] == 2'h2 ? p[3] : c[5:4] == 2'h3 && p[5],
               (c[1] ? p[1] : p[0]) & c[3], (c[0] ? p[2] : p[0]) & c[2]};
   endfunction
   task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
      begin
         checked = checked + 1;
         if (g !== e) begin
            err_count = err_count + 1;
            $display("mismatch %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      begin
         @(negedge mclk);
         {io_sel, io_wr, io_addr, io_wdata} = {2'h3, a, d};
         @(negedge mclk);
         {io_sel, io_wr} = 2'h0;
      end
   endtask
   task rd(input [2:0] a, input [7:0] e);
      begin
         @(negedge mclk);
         {io_sel, io_rd, io_addr} = {2'h3, a};
         @(negedge mclk);
         // Answer stands for the one cycle after the strobe edge
         chk("rvalid", 8'h01, {7'h00, io_rvalid});
         chk("rdata", e, io_rdata);
         {io_sel, io_rd} = 2'h0;
      end
   endtask
   task end_sim;
      begin
         if (err_count == 0 && checked > 0)
            $display("SIMULATION PASSED");
         else
            $display("SIMULATION FAILED");
         $finish;
      end
   endtask
   // Watchdog, about three times the expected run
   initial begin
      #200000;
      err_count = err_count + 1;
      end_sim;
   end
   // Reset, unmapped offsets, random routing, then line control in both straps
   initial begin
      repeat (4) @(negedge mclk);
      sys_rst = 1'b0;
      rd(3'h4, 8'h00);
      chk("outs", 8'h00, outs);
      for (i = 0; i < 6; i = i + 1) begin
         wr((i < 4) ? i[2:0] : i[2:0] + 3'h2, 8'hff);
         rd((i < 4) ? i[2:0] : i[2:0] + 3'h2, 8'h00);
      end
      rd(3'h4, 8'h00);
      rd(3'h5, 8'h00);
      for (i = 0; i < 40; i = i + 1) begin
         rnd = xs(rnd);
         v = rnd[7:0];
         if (i < 4) v[5:4] = i[1:0];
         if (v[3:2] == 2'h3 && v[1:0] == 2'h0) v[0] = 1'b1;
         lv = rnd[13:8];
         wr(3'h5, v); // Gate set after controller request armed
         repeat (5) @(negedge mclk);
         chk("route", {5'h00, route(v[5:0], lv)}, {5'h00, outs[2:0]});
         rd(3'h5, {2'h0, v[5:0]});
      end
      lx = 4'h0;
      for (i = 0; i < 32; i = i + 1) begin
         rnd = xs(rnd);
         if (i[2:0] == 3'h0) begin
            dce = i[3];
            jmp = rnd[17];
            lv = rnd[13:8];
            repeat (5) @(negedge mclk);
         end
         v = rnd[7:0] & 8'hfc;
         if (v[5]) v[4] = 1'b0;
         wr(3'h4, v);
         lx[5:4] = v[5:4];
         if (dce) lx[3] = v[3];
         else lx[2] = v[2];
         repeat (5) @(negedge mclk);
         rd(3'h4, {lv[5], 1'b0, lx, 2'h0});
         chk("line", {lx[5:4], lx[4] & jmp, lx[3] & dce, lx[2] | dce, 3'h0},
             {outs[7:3], 3'h0});
      end
      end_sim;
   end
endmodule // tb_dirlc_top
